// File: dv/qdrl_host.sv
// Host model of the flash pins: chip select, serial clock, four I/O lines.
// Assumes the bench resolves io from io_oe and hands the result back here.
`timescale 1ns/1ps
module qdrl_host (
  input wire logic ref_clk,
  input wire logic [3:0] io,
  output logic cs_n,
  output logic sck,
  output logic [3:0] drv
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    drv = 4'h0;
  end
  // Half of a 125 ns sck period; cs_n falls on a ref_clk fall and the other pins
  // move from 1 ns after it, so no pin edge lands on a rising ref_clk edge
  task automatic half();
    #62.5;
  endtask
  task automatic tick();
    half();
    sck = ~sck;
  endtask
  // Data moves half-way between sck edges, so both edges see it settled
  task automatic put(input logic [3:0] n);
    #31.25;
    drv = n;
    #31.25;
    sck = ~sck;
  endtask
  task automatic start();
    cs_n = 1'b0;
    #1;
  endtask
  task automatic stop();
    half();
    cs_n = 1'b1;
    drv = ~drv;
    half();
    @(negedge ref_clk);
  endtask
  task automatic op(input logic [7:0] c, input logic four);
    if (four) begin
      put(c[7:4]);
      tick();
      put(c[3:0]);
      tick();
    end else begin
      for (int i = 7; i >= 0; i--) begin
        put({3'h0, c[i]});
        tick();
      end
    end
  endtask
  // sel 0: nibble per edge, 1: nibble per fall, 2: io1 bit per fall
  task automatic collect(input int n, input int sel, output logic [63:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      if (sel != 0)
        tick();
      half();
      v = (sel == 2) ? {v[62:0], io[1]} : {v[59:0], io};
      sck = ~sck;
    end
  endtask
  task automatic qread(input logic four, input logic cont,
                       input logic [23:0] a, input logic [3:0] m,
                       input logic [3:0] n, output logic [63:0] v);
    start();
    if (!cont)
      op(8'hED, four);
    for (int i = 5; i >= 0; i--)
      put(a[i*4 +: 4]);
    put(m);
    // Released lines show the inverse so a stale value cannot pass
    put(~m);
    for (int i = 1; i < n; i++) begin
      tick();
      tick();
    end
    collect(4, 0, v);
    stop();
  endtask
  task automatic unlock(input logic [23:0] a);
    start();
    op(8'h26, 1'b0);
    for (int i = 23; i >= 0; i--) begin
      put({3'h0, a[i]});
      tick();
    end
    stop();
  endtask
  task automatic relock();
    start();
    op(8'h24, 1'b0);
    stop();
  endtask
  task automatic boot(input int d, input int sel, input int n,
                      output logic [63:0] v);
    start();
    repeat (2 * d) tick();
    collect(n, sel, v);
    stop();
  endtask
  task automatic bootreg(output logic [63:0] v);
    start();
    op(8'h14, 1'b0);
    collect(32, 2, v);
    stop();
  endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the quad read, sector lock and boot engine.
// Assumes qdrl_host drives the pins; the array is a fixed address function.
`timescale 1ns/1ps
module testbench;
  import qdrl_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  qdrl_pins_t pins;
  qdrl_stat_t stat = '0;
  logic [3:0] read_dummy_cycles = DUMMY_DEFAULT;
  logic [31:0] boot_reg = 32'hFFFFFF07;
  logic boot_rearm = 1'b0;
  logic [23:0] chk_addr = 24'h000000;
  logic [3:0] io_o, io_oe, drv, io;
  logic [23:0] mem_addr;
  logic [7:0] rd_data;
  logic [11:0] unlock_sector;
  logic cs_n, sck, chk_writable, unlock_valid, cont_mode, boot_active;
  logic oe_seen = 1'b0;
  logic boot_seen = 1'b0;
  logic [63:0] v;
  int fails = 0;
  int comparisons = 0;
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] + a[23:16] + 8'h11;
  endfunction
  always #5 ref_clk = ~ref_clk;
  assign io = (io_oe & io_o) | (~io_oe & drv);
  assign pins = {cs_n, sck, io};
  assign rd_data = mem(mem_addr);
  always @(posedge ref_clk)
    if (io_oe != 4'h0)
      oe_seen <= 1'b1;
  always @(posedge ref_clk)
    if (boot_active)
      boot_seen <= 1'b1;
  qdrl_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .pins(pins),
    .io_o(io_o), .io_oe(io_oe), .stat(stat),
    .read_dummy_cycles(read_dummy_cycles), .boot_reg(boot_reg),
    .boot_rearm(boot_rearm), .rd_data(rd_data), .mem_addr(mem_addr),
    .chk_addr(chk_addr), .chk_writable(chk_writable),
    .unlock_valid(unlock_valid), .unlock_sector(unlock_sector),
    .cont_mode(cont_mode), .boot_active(boot_active));
  qdrl_host host (.ref_clk(ref_clk), .io(io), .cs_n(cs_n), .sck(sck),
    .drv(drv));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [23:0] a, input logic exp);
    @(negedge ref_clk);
    chk_addr = a;
    repeat (2) @(negedge ref_clk);
    chk(chk_writable, exp);
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    stat.qe = 1'b1;
    host.boot(3, 1, 4, v);
    chk(v[15:0], {mem(24'hFFFFFF), mem(24'h0)});
    chk({boot_seen, boot_active}, 2'b10);
    boot_seen = 1'b0;
    host.qread(0, 0, 24'h123456, 4'hA, 4'h6, v);
    chk(v[15:0], {mem(24'h123456), mem(24'h123457)});
    chk(boot_seen, 1'b0);
    chk(cont_mode, 1'b1);
    host.qread(0, 1, 24'hFFFFFF, 4'h5, 4'h6, v);
    chk(v[15:0], {mem(24'hFFFFFF), mem(24'h0)});
    chk(cont_mode, 1'b0);
    stat.four_line = 1'b1;
    read_dummy_cycles = 4'h4;
    host.qread(1, 0, 24'h00ABCD, 4'h0, 4'h4, v);
    chk(v[15:0], {mem(24'h00ABCD), mem(24'h00ABCE)});
    stat.four_line = 1'b0;
    read_dummy_cycles = DUMMY_DEFAULT;
    // First pass quad disabled, second pass a write still running
    for (int k = 0; k < 2; k++) begin
      stat.qe = k[0];
      stat.write_in_progress_flag = k[0];
      oe_seen = 1'b0;
      host.qread(0, 0, 24'h000010, 4'h0, 4'h6, v);
      chk(oe_seen, 1'b0);
    end
    stat.write_in_progress_flag = 1'b0;
    stat.qe = 1'b1;
    stat.bp = 4'h1;
    wr(24'hFF3000, 1'b0);
    host.unlock(24'h120000);
    chk(unlock_valid, 1'b0);
    host.unlock(24'hFF3ABC);
    chk({unlock_valid, unlock_sector}, {1'b1, 12'hFF3});
    wr(24'hFF3FFF, 1'b1);
    wr(24'hFF4000, 1'b0);
    wr(24'h000000, 1'b1);
    host.unlock(24'hFF5000);
    chk(unlock_sector, 12'hFF3);
    host.relock();
    chk(unlock_valid, 1'b0);
    wr(24'hFF3000, 1'b0);
    host.unlock(24'hFF5000);
    chk({unlock_valid, unlock_sector}, {1'b1, 12'hFF5});
    host.bootreg(v);
    chk(v[31:0], {boot_reg[7:0], boot_reg[15:8], boot_reg[23:16],
                  boot_reg[31:24]});
    boot_reg = 32'h00100005;
    stat.qe = 1'b0;
    boot_rearm = 1'b1;
    @(negedge ref_clk);
    boot_rearm = 1'b0;
    repeat (4) @(negedge ref_clk);
    host.boot(2, 2, 16, v);
    chk(v[15:0], {mem(24'h001000), mem(24'h001001)});
    chk(boot_seen, 1'b1);
    end_of_test();
  end
  initial begin
    #500000;
    fails++;
    end_of_test();
  end
endmodule

// File: verilog/qdrl_core.sv
// Command engine: quad DTR read, sector lock/unlock, boot streaming read.
// Assumes rd_data returns the array byte at mem_addr in the same cycle and
// that status bits come from logic on ref_clk.
`timescale 1ns/1ps
module qdrl_core (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire qdrl_pkg::qdrl_pins_t pins,
  output logic [3:0] io_o,
  output logic [3:0] io_oe,
  input wire qdrl_pkg::qdrl_stat_t stat,
  input wire logic [3:0] read_dummy_cycles,
  input wire logic [31:0] boot_reg,
  input wire logic boot_rearm,
  input wire logic [7:0] rd_data,
  output logic [23:0] mem_addr,
  input wire logic [23:0] chk_addr,
  output logic chk_writable,
  output logic unlock_valid,
  output logic [11:0] unlock_sector,
  output logic cont_mode,
  output logic boot_active
);
  import qdrl_pkg::*;

  qdrl_pins_t pins_s;
  qdrl_state_t st_q, st_d;
  qdrl_mode_t mode_q;
  qdrl_cmd_t cmd_q;
  logic sck_d_q, cs_d_q, cont_q, armed_q, bootfrm_q, bootrd_q;
  logic [4:0] bc_q;
  logic [7:0] op_q;
  logic [23:0] addr_q, mem_addr_q;
  logic [3:0] dly_q, cnt_q, io_o_q, oe_q;
  logic [2:0] pc_q;
  logic uv_q, wr_q;
  logic [11:0] usec_q;

  qdrl_sync #(.W(6), .INIT(PINS_IDLE)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .din(pins),
    .dout(pins_s)
  );

  wire [3:0] io_s = pins_s.io;
  wire rise = pins_s.sck & ~sck_d_q;
  wire fall = ~pins_s.sck & sck_d_q;
  wire cs_fall = ~pins_s.cs_n & cs_d_q;
  wire cs_rise = pins_s.cs_n & ~cs_d_q;
  wire qe = stat.qe;

  // Boot register fields
  wire boot_go = armed_q & boot_reg[BOOT_EN_BIT];
  wire [3:0] boot_dly = boot_reg[BOOT_DLY_LSB +: 4];
  wire [23:0] boot_addr = boot_reg[BOOT_ADDR_LSB +: 24];

  // Opcode phase
  wire [4:0] op_step = stat.four_line ? STEP_QUAD : STEP_ONE;
  wire [7:0] op_nx = stat.four_line ? {op_q[3:0], io_s} :
                     {op_q[6:0], io_s[0]};
  wire opc_done = (st_q == S_OPC) && rise &&
                  (bc_q + op_step == OPC_BITS);
  wire is_rd = op_nx == OP_QDR_READ;
  wire is_ul = op_nx == OP_SEC_UNLOCK;
  wire is_rl = op_nx == OP_SEC_RELOCK;
  wire is_br = op_nx == OP_BOOT_RD;
  wire rd_ok = is_rd & qe & ~stat.write_in_progress_flag;
  wire qdrl_state_t op_st = (rd_ok | is_ul) ? S_ADDR :
                            is_br ? S_DATA : S_WAIT;
  wire qdrl_cmd_t op_cmd = rd_ok ? C_READ : is_ul ? C_UNLOCK :
                           is_rl ? C_RELOCK : C_NONE;

  // Address phase: quad read takes a nibble on each edge
  wire ddr = cmd_q == C_READ;
  wire a_quad = ddr | stat.four_line;
  wire [4:0] a_step = a_quad ? STEP_QUAD : STEP_ONE;
  // The fall that closes the last opcode clock is not an address edge
  wire a_edge = ddr ? (rise | (fall & (bc_q != 5'h00))) : rise;
  wire [23:0] addr_nx = a_quad ? {addr_q[19:0], io_s} :
                        {addr_q[22:0], io_s[0]};
  wire addr_done = (st_q == S_ADDR) && a_edge &&
                   (bc_q + a_step == ADDR_BITS);
  wire dly0 = read_dummy_cycles == 4'h0;
  wire [11:0] sect_in = addr_q[23:SECT_LSB];

  // Dummy and data phases
  wire last_dummy = (st_q == S_DUMMY) && fall && (cnt_q + 4'h1 == dly_q);
  wire out_edge = (mode_q == M_QDDR) ? (rise | fall) : fall;
  wire emit = ((st_q == S_DATA) && out_edge) || last_dummy;
  wire [7:0] src = bootrd_q ? boot_reg[{mem_addr_q[1:0], 3'h0} +: 8] :
                   rd_data;
  wire p_last = (mode_q == M_SER) ? (pc_q == SER_LAST) : (pc_q == QUAD_LAST);
  wire [3:0] nib = pc_q[0] ? src[3:0] : src[7:4];
  wire [3:0] piece = (mode_q == M_SER) ?
                     {2'h0, src[3'h7 - pc_q], 1'h0} : nib;
  wire [3:0] oe_d = (mode_q == M_SER) ? OE_SER : OE_QUAD;
  wire ul_ok = ~uv_q & qdrl_is_prot(addr_q[23:BLK_LSB], stat.bp, stat.top_bottom_select_bit);

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (cs_fall)
          st_d = boot_go ? ((boot_dly == 4'h0) ? S_DATA : S_DUMMY) :
                 cont_q ? S_ADDR : S_OPC;
      end
      S_OPC: begin
        if (opc_done)
          st_d = op_st;
      end
      S_ADDR: begin
        if (addr_done)
          st_d = (cmd_q != C_READ) ? S_WAIT : dly0 ? S_DATA : S_DUMMY;
      end
      S_DUMMY: begin
        if (last_dummy)
          st_d = S_DATA;
      end
      S_DATA, S_WAIT: st_d = st_q;
      default: st_d = S_IDLE;
    endcase
    // Frame end aborts any phase
    if (cs_rise)
      st_d = S_IDLE;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      sck_d_q <= 1'b0;
      cs_d_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sck_d_q <= pins_s.sck;
      cs_d_q <= pins_s.cs_n;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q <= C_NONE;
      mode_q <= M_SER;
      bootrd_q <= 1'b0;
      dly_q <= 4'h0;
    end else if (cs_fall && st_q == S_IDLE) begin
      cmd_q <= (cont_q && !boot_go) ? C_READ : C_NONE;
      mode_q <= boot_go ? (qe ? M_QSDR : M_SER) : M_QDDR;
      bootrd_q <= 1'b0;
      dly_q <= boot_go ? boot_dly : read_dummy_cycles;
    end else if (opc_done) begin
      cmd_q <= op_cmd;
      mode_q <= is_br ? M_SER : M_QDDR;
      bootrd_q <= is_br;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bc_q <= 5'h00;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (cs_fall || opc_done) begin
      bc_q <= 5'h00;
    end else if (st_q == S_OPC && rise) begin
      bc_q <= bc_q + op_step;
      op_q <= op_nx;
    end else if (st_q == S_ADDR && a_edge) begin
      // The last bit lands too: unlock takes its sector from addr_q
      bc_q <= addr_done ? 5'h00 : bc_q + a_step;
      addr_q <= addr_nx;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      cnt_q <= 4'h0;
    else if (cs_fall)
      cnt_q <= 4'h0;
    else if (st_q == S_DUMMY && fall)
      cnt_q <= cnt_q + 4'h1;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      mem_addr_q <= 24'h000000;
    else if (cs_fall && st_q == S_IDLE && boot_go)
      mem_addr_q <= boot_addr;
    else if (opc_done && is_br)
      mem_addr_q <= 24'h000000;
    else if (addr_done && cmd_q == C_READ)
      mem_addr_q <= addr_nx;
    else if (emit && p_last)
      mem_addr_q <= mem_addr_q + 24'h000001;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= 3'h0;
      io_o_q <= 4'h0;
      oe_q <= OE_OFF;
    end else if (cs_rise || cs_fall) begin
      pc_q <= 3'h0;
      oe_q <= OE_OFF;
    end else if (emit) begin
      pc_q <= p_last ? 3'h0 : pc_q + 3'h1;
      io_o_q <= piece;
      oe_q <= oe_d;
    end
  end

  // Mode nibble is the first edge of the first dummy clock
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      cont_q <= 1'b0;
    else if (st_q == S_DUMMY && rise && cnt_q == 4'h0 && cmd_q == C_READ)
      cont_q <= io_s == CONT_MODE_HI;
  end

  // Armed by reset or boot_rearm; a frame with boot disabled also uses it up
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_q <= 1'b1;
      bootfrm_q <= 1'b0;
    end else if (boot_rearm) begin
      armed_q <= 1'b1;
    end else if (cs_fall && st_q == S_IDLE) begin
      armed_q <= 1'b0;
      bootfrm_q <= boot_go;
    end else if (cs_rise) begin
      bootfrm_q <= 1'b0;
    end
  end

  // Unlock while one is held is dropped rather than replacing it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      uv_q <= 1'b0;
      usec_q <= 12'h000;
    end else if (cs_rise && st_q == S_WAIT && cmd_q == C_RELOCK) begin
      uv_q <= 1'b0;
    end else if (cs_rise && st_q == S_WAIT && cmd_q == C_UNLOCK && ul_ok) begin
      uv_q <= 1'b1;
      usec_q <= sect_in;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst)
      wr_q <= 1'b0;
    else
      wr_q <= ~qdrl_is_prot(chk_addr[23:BLK_LSB], stat.bp, stat.top_bottom_select_bit) |
              (uv_q & (chk_addr[23:SECT_LSB] == usec_q));
  end

  assign io_o = io_o_q;
  assign io_oe = oe_q;
  assign mem_addr = mem_addr_q;
  assign chk_writable = wr_q;
  assign unlock_valid = uv_q;
  assign unlock_sector = usec_q;
  assign cont_mode = cont_q;
  assign boot_active = bootfrm_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_rd_opcode;
    opc_done && is_rd;
  endsequence
  sequence s_boot_start;
    cs_fall && st_q == S_IDLE && boot_go;
  endsequence
  sequence s_relock;
    cs_rise && st_q == S_WAIT && cmd_q == C_RELOCK;
  endsequence

  property p_qe_gate;
    s_rd_opcode ##0 !qe |=> st_q == S_WAIT && cmd_q == C_NONE;
  endproperty
  a_qe_gate: assert property (p_qe_gate)
    else $error("quad read served with quad enable low");

  property p_wip_gate;
    s_rd_opcode ##0 stat.write_in_progress_flag |=> st_q == S_WAIT && cmd_q == C_NONE;
  endproperty
  a_wip_gate: assert property (p_wip_gate)
    else $error("quad read served during write in progress");

  property p_ddr_nib;
    rise && st_q == S_DATA && mode_q == M_QDDR |=> io_o_q == $past(nib);
  endproperty
  a_ddr_nib: assert property (p_ddr_nib)
    else $error("no nibble driven on rising edge");

  property p_addr_inc;
    emit && p_last |=> mem_addr_q == $past(mem_addr_q) + 24'h000001;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("address not incremented after byte");

  property p_opc_len;
    st_q == S_OPC && rise && ((!stat.four_line && bc_q == 5'h07) ||
      (stat.four_line && bc_q == 5'h04)) && !cs_rise |=> st_q != S_OPC;
  endproperty
  a_opc_len: assert property (p_opc_len)
    else $error("opcode phase wrong length");

  property p_cont_set;
    st_q == S_DUMMY && rise && cnt_q == 4'h0 && cmd_q == C_READ &&
      io_s == CONT_MODE_HI |=> cont_q;
  endproperty
  a_cont_set: assert property (p_cont_set)
    else $error("mode nibble A did not enter continuous read");

  property p_cont_skip;
    cs_fall && st_q == S_IDLE && cont_q && !boot_go
      |=> st_q == S_ADDR && cmd_q == C_READ;
  endproperty
  a_cont_skip: assert property (p_cont_skip)
    else $error("continuous read did not skip opcode");

  property p_one_unlock;
    uv_q && $past(uv_q) |-> usec_q == $past(usec_q);
  endproperty
  a_one_unlock: assert property (p_one_unlock)
    else $error("unlocked sector replaced while held");

  property p_unlock_addr;
    $rose(uv_q) |-> usec_q == $past(sect_in);
  endproperty
  a_unlock_addr: assert property (p_unlock_addr)
    else $error("unlocked sector not from address bits 23:12");

  property p_relock;
    s_relock |=> !uv_q;
  endproperty
  a_relock: assert property (p_relock)
    else $error("relock left sector unlocked");

  property p_boot_go;
    s_boot_start |=> bootfrm_q && mem_addr_q == $past(boot_addr) &&
      dly_q == $past(boot_dly) && mode_q == ($past(qe) ? M_QSDR : M_SER);
  endproperty
  a_boot_go: assert property (p_boot_go)
    else $error("boot read did not start as configured");

  property p_boot_once;
    bootfrm_q && cs_rise && !boot_rearm |=> !armed_q ##1 !armed_q;
  endproperty
  a_boot_once: assert property (p_boot_once)
    else $error("boot read re-armed without reset");

  property p_brd_msb;
    emit && bootrd_q && pc_q == 3'h0 |=> io_o_q[1] == $past(src[7]);
  endproperty
  a_brd_msb: assert property (p_brd_msb)
    else $error("boot register byte not MSB first");
endmodule

// File: verilog/qdrl_pkg.sv
// Constants, types and helpers for the quad read, sector lock and boot block.
// Assumes a host driving cs_n, sck and io in SPI mode 0 or 3, sck slow
// against ref_clk (at least 8 ref_clk cycles per sck period).
package qdrl_pkg;
  localparam logic [7:0] OP_QDR_READ = 8'hED;
  localparam logic [7:0] OP_SEC_UNLOCK = 8'h26;
  localparam logic [7:0] OP_SEC_RELOCK = 8'h24;
  localparam logic [7:0] OP_BOOT_RD = 8'h14;
  localparam logic [3:0] CONT_MODE_HI = 4'hA;
  // Usual setting for the read_dummy_cycles port
  localparam logic [3:0] DUMMY_DEFAULT = 4'h6;
  localparam logic [4:0] OPC_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] STEP_ONE = 5'h01;
  localparam logic [4:0] STEP_QUAD = 5'h04;
  localparam logic [2:0] SER_LAST = 3'h7;
  localparam logic [2:0] QUAD_LAST = 3'h1;
  localparam logic [3:0] OE_SER = 4'h2;
  localparam logic [3:0] OE_QUAD = 4'hF;
  localparam logic [3:0] OE_OFF = 4'h0;
  localparam int SECT_LSB = 12;
  localparam int BLK_LSB = 16;
  localparam int BOOT_EN_BIT = 0;
  localparam int BOOT_DLY_LSB = 1;
  localparam int BOOT_ADDR_LSB = 8;
  localparam logic [5:0] PINS_IDLE = 6'h20;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_OPC = 6'h02, S_ADDR = 6'h04,
    S_DUMMY = 6'h08, S_DATA = 6'h10, S_WAIT = 6'h20
  } qdrl_state_t;
  typedef enum logic [1:0] {M_SER, M_QSDR, M_QDDR} qdrl_mode_t;
  typedef enum logic [1:0] {C_NONE, C_READ, C_UNLOCK, C_RELOCK} qdrl_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic [3:0] io;
  } qdrl_pins_t;

  typedef struct packed {
    logic write_in_progress_flag;
    logic qe;
    logic four_line;
    logic top_bottom_select_bit;
    logic [3:0] bp;
  } qdrl_stat_t;

  // Protected 64 KB block test: bp selects 2^(bp-1) blocks from top or
  // bottom, bp of 9 and above protects everything.
  function automatic logic qdrl_is_prot(input logic [7:0] blk,
                                        input logic [3:0] bp,
                                        input logic top_bottom_select_bit);
    logic [8:0] n;
    n = (bp >= 4'h9) ? 9'h100 : (9'h001 << (bp - 4'h1));
    if (bp == 4'h0)
      return 1'b0;
    return top_bottom_select_bit ? ({1'b0, blk} < n) : ({1'b0, blk} >= (9'h100 - n));
  endfunction
endpackage

// File: verilog/qdrl_sync.sv
// Two-flop synchroniser for the flash pins.
// Assumes the inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
module qdrl_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= INIT;
      dout <= INIT;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule
